/* hdl/atls_params.svh */
// Register offsets, field positions, reset values and timing counts of the learning sequencer.
`ifndef ATLS_PARAMS_SVH
`define ATLS_PARAMS_SVH

// =============================================================================
// Register byte addresses
`define ATLS_ADDR_CONFIG      8'h00
`define ATLS_ADDR_CONTROL     8'h04
`define ATLS_ADDR_STATUS      8'h08
`define ATLS_ADDR_CONST_LOW   8'h0C
`define ATLS_ADDR_CONST_HIGH  8'h10
`define ATLS_ADDR_CEILING     8'h14
`define ATLS_ADDR_THRESHOLD   8'h18
`define ATLS_ADDR_LOSS        8'h1C

// =============================================================================
// Field positions
`define ATLS_CFG_INIT_LSB     0
`define ATLS_CFG_INIT_MSB     4
`define ATLS_CFG_INC_LSB      8
`define ATLS_CFG_INC_MSB      9
`define ATLS_CFG_DWELL_LSB    12
`define ATLS_CFG_DWELL_MSB    13
`define ATLS_CTL_GO_BIT       0
`define ATLS_CTL_ENABLE_BIT   1
`define ATLS_CTL_SUPPLY_BIT   2
`define ATLS_STS_DONE_BIT     0
`define ATLS_STS_BUSY_BIT     1
`define ATLS_STS_PHASE_BIT    2

// =============================================================================
// Reset values and constants
`define ATLS_RST_INIT         5'h00
`define ATLS_RST_INC          2'h0
`define ATLS_RST_DWELL        2'h0
`define ATLS_RST_CONST        11'h000
`define ATLS_RST_CEILING      8'hFF
`define ATLS_RST_THRESHOLD    8'h00
`define ATLS_LEVEL_SCALE      3
`define ATLS_DWELL_UNIT       6'h08
`define ATLS_VM_NOMINAL       12'h800

`endif

/* hdl/atls_pkg.sv */
// Types shared by the learning sequencer modules.
package atls_pkg;

	// =========================================================================
	// Sequencer states
	typedef enum logic [1:0] {
		atls_idle,
		atls_initial,
		atls_final
	} atls_state_type;

endpackage : atls_pkg

/* hdl/atls_sync.sv */
// Two flip-flop synchroniser for a pin-level input.
`timescale 1ns/1ps
`default_nettype none

module atls_sync (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic pin_in,
	output logic      sync_out
);

	// =========================================================================
	// Synchroniser stages
	logic stage_one;
	logic next_stage_one;
	logic next_sync_out;

	always_comb begin
		next_stage_one = pin_in;
		next_sync_out  = stage_one;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage_one <= 1'b0;
			sync_out  <= 1'b0;
		end else begin
			stage_one <= next_stage_one;
			sync_out  <= next_sync_out;
		end
	end

endmodule : atls_sync

`default_nettype wire

/* hdl/atls_scale.sv */
// Supply-compensated rescaling of an 11-bit value.
`timescale 1ns/1ps
`default_nettype none

module atls_scale (
	input  wire logic        enable,
	input  wire logic [11:0] supply_level,
	input  wire logic [10:0] value_in,
	output logic      [10:0] value_out
);

	`include "atls_params.svh"

	// =========================================================================
	// Rescaling
	logic [22:0] product;
	logic [22:0] quotient;

	// Losses scale inversely with supply, so the value is multiplied by nominal over actual.
	always_comb begin
		product  = 23'(value_in) * 23'(`ATLS_VM_NOMINAL);
		quotient = (supply_level == 12'h000) ? product : product / 23'(supply_level);
		if (!enable) begin
			value_out = value_in;
		end else if (quotient > 23'h0007FF) begin
			value_out = 11'h7FF;
		end else begin
			value_out = quotient[10:0];
		end
	end

endmodule : atls_scale

`default_nettype wire

/* hdl/atls_sequencer.sv */
// Learning sequencer for the load-adaptive current algorithm with its register slave.
// Functional notes
// - A five-bit field selects the initial learning current level.
// - Initial current is field times eight; final adds the increment.
// - Increment code decodes to 128, 16, 32 or 64.
// - Dwell code decodes to 8, 16, 24 or 32 half-cycles.
// - Writing one to go starts learning; go clears when learning ends.
// - The complete flag becomes one when learning finishes.
// - Learning first drives the initial level for the dwell count.
// - Then the final level is driven for the same dwell count.
// - Loss at the initial level is stored in the low constant.
// - Loss at the final level is stored in the high constant.
// - On completion the current goes to the configured ceiling.
// - Supply compensation rescales the upper threshold and loss values.
// - Software may write stored constants directly; they are accepted.
// - Writing one to the enable bit enables adaptive current.
// - Loss is interpolated linearly from the two constants.
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module atls_sequencer
	import atls_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        half_cycle_pulse,
	input  wire logic [10:0] measured_loss,
	input  wire logic [11:0] supply_level,
	input  wire logic [7:0]  operating_current,
	output logic      [7:0]  current_command,
	output logic             current_override,
	output logic             adaptive_current_enable,
	output logic      [7:0]  band_upper_threshold,
	output logic      [10:0] no_load_loss_parameter
);

	`include "atls_params.svh"

	// =========================================================================
	// Registers
	logic [4:0]      learn_initial_level;
	logic [1:0]      learn_increment_select;
	logic [1:0]      learn_dwell_select;
	logic            learn_go;
	logic            learn_complete_flag;
	logic            enable_bit;
	logic            supply_compensation_enable;
	logic [10:0]     learned_constant_low;
	logic [10:0]     learned_constant_high;
	logic [7:0]      adaptive_current_ceiling;
	logic [7:0]      threshold_raw;
	logic            access_done;
	atls_state_type  state;
	logic [5:0]      dwell_count;
	logic [7:0]      command_reg;
	logic            override_reg;
	logic [31:0]     readdata_reg;
	logic [10:0]     loss_reg;

	logic [4:0]      next_learn_initial_level;
	logic [1:0]      next_learn_increment_select;
	logic [1:0]      next_learn_dwell_select;
	logic            next_learn_go;
	logic            next_learn_complete_flag;
	logic            next_enable_bit;
	logic            next_supply_compensation_enable;
	logic [10:0]     next_learned_constant_low;
	logic [10:0]     next_learned_constant_high;
	logic [7:0]      next_adaptive_current_ceiling;
	logic [7:0]      next_threshold_raw;
	logic            next_access_done;
	atls_state_type  next_state;
	logic [5:0]      next_dwell_count;
	logic [7:0]      next_command_reg;
	logic            next_override_reg;
	logic [31:0]     next_readdata_reg;
	logic [10:0]     next_loss_reg;

	// =========================================================================
	// Derived values
	logic            half_cycle_sync;
	logic            half_cycle_prev;
	logic            half_cycle_edge;
	logic [8:0]      initial_current;
	logic [8:0]      increment_value;
	logic [8:0]      final_current;
	logic [5:0]      dwell_target;
	logic [10:0]     scaled_low;
	logic [10:0]     scaled_high;
	logic [10:0]     scaled_threshold;
	logic            write_go;
	logic            learn_finish;

	// The pulse comes from the indexer domain and is resynchronised before use.
	atls_sync u_half_cycle_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.pin_in   (half_cycle_pulse),
		.sync_out (half_cycle_sync)
	);

	assign half_cycle_edge = half_cycle_sync & ~half_cycle_prev;

	always_comb begin
		initial_current = {1'b0, learn_initial_level, 3'h0};
		case (learn_increment_select)
			2'h0:    increment_value = 9'h080;
			2'h1:    increment_value = 9'h010;
			2'h2:    increment_value = 9'h020;
			default: increment_value = 9'h040;
		endcase
		final_current = initial_current + increment_value;
		dwell_target  = `ATLS_DWELL_UNIT * (6'(learn_dwell_select) + 6'h01);
	end

	atls_scale u_scale_low (
		.enable       (supply_compensation_enable),
		.supply_level (supply_level),
		.value_in     (learned_constant_low),
		.value_out    (scaled_low)
	);

	atls_scale u_scale_high (
		.enable       (supply_compensation_enable),
		.supply_level (supply_level),
		.value_in     (learned_constant_high),
		.value_out    (scaled_high)
	);

	atls_scale u_scale_threshold (
		.enable       (supply_compensation_enable),
		.supply_level (supply_level),
		.value_in     ({3'h0, threshold_raw}),
		.value_out    (scaled_threshold)
	);

	// =========================================================================
	// Bus slave and sequencer
	always_comb begin
		next_learn_initial_level        = learn_initial_level;
		next_learn_increment_select     = learn_increment_select;
		next_learn_dwell_select         = learn_dwell_select;
		next_learn_go                   = learn_go;
		next_learn_complete_flag        = learn_complete_flag;
		next_enable_bit                 = enable_bit;
		next_supply_compensation_enable = supply_compensation_enable;
		next_learned_constant_low       = learned_constant_low;
		next_learned_constant_high      = learned_constant_high;
		next_adaptive_current_ceiling   = adaptive_current_ceiling;
		next_threshold_raw              = threshold_raw;
		next_state                      = state;
		next_dwell_count                = dwell_count;
		next_command_reg                = command_reg;
		next_override_reg               = override_reg;
		next_readdata_reg               = readdata_reg;
		next_access_done                = 1'b0;
		write_go                        = 1'b0;
		learn_finish                    = 1'b0;

		// Every access takes exactly one wait cycle, so the answer is on the second edge.
		if ((avs_read || avs_write) && !access_done) begin
			next_access_done = 1'b1;
		end
		// Writes commit only at the edge that ends the wait, so nothing lands while stalled.
		if (avs_read || avs_write) begin
			if (avs_write && access_done) begin
				case (avs_address)
					`ATLS_ADDR_CONFIG: begin
						if (avs_byteenable[0]) begin
							next_learn_initial_level = avs_writedata[`ATLS_CFG_INIT_MSB:`ATLS_CFG_INIT_LSB];
						end
						if (avs_byteenable[1]) begin
							next_learn_increment_select = avs_writedata[`ATLS_CFG_INC_MSB:`ATLS_CFG_INC_LSB];
							next_learn_dwell_select = avs_writedata[`ATLS_CFG_DWELL_MSB:`ATLS_CFG_DWELL_LSB];
						end
					end
					`ATLS_ADDR_CONTROL: begin
						if (avs_byteenable[0]) begin
							write_go = avs_writedata[`ATLS_CTL_GO_BIT];
							next_enable_bit = avs_writedata[`ATLS_CTL_ENABLE_BIT];
							next_supply_compensation_enable = avs_writedata[`ATLS_CTL_SUPPLY_BIT];
						end
					end
					`ATLS_ADDR_CONST_LOW: begin
						if (avs_byteenable[0]) begin
							next_learned_constant_low[7:0] = avs_writedata[7:0];
						end
						if (avs_byteenable[1]) begin
							next_learned_constant_low[10:8] = avs_writedata[10:8];
						end
					end
					`ATLS_ADDR_CONST_HIGH: begin
						if (avs_byteenable[0]) begin
							next_learned_constant_high[7:0] = avs_writedata[7:0];
						end
						if (avs_byteenable[1]) begin
							next_learned_constant_high[10:8] = avs_writedata[10:8];
						end
					end
					`ATLS_ADDR_CEILING: begin
						if (avs_byteenable[0]) begin
							next_adaptive_current_ceiling = avs_writedata[7:0];
						end
					end
					`ATLS_ADDR_THRESHOLD: begin
						if (avs_byteenable[0]) begin
							next_threshold_raw = avs_writedata[7:0];
						end
					end
					default: begin
					end
				endcase
			end else if (avs_read && !access_done) begin
				case (avs_address)
					`ATLS_ADDR_CONFIG: next_readdata_reg = {18'h0, learn_dwell_select, 2'h0,
						learn_increment_select, 3'h0, learn_initial_level};
					`ATLS_ADDR_CONTROL: next_readdata_reg = {29'h0, supply_compensation_enable,
						enable_bit, learn_go};
					`ATLS_ADDR_STATUS: next_readdata_reg = {29'h0, state == atls_final,
						state != atls_idle, learn_complete_flag};
					`ATLS_ADDR_CONST_LOW:  next_readdata_reg = {21'h0, learned_constant_low};
					`ATLS_ADDR_CONST_HIGH: next_readdata_reg = {21'h0, learned_constant_high};
					`ATLS_ADDR_CEILING:    next_readdata_reg = {24'h0, adaptive_current_ceiling};
					`ATLS_ADDR_THRESHOLD:  next_readdata_reg = {24'h0, threshold_raw};
					`ATLS_ADDR_LOSS:       next_readdata_reg = {21'h0, loss_reg};
					default:               next_readdata_reg = 32'h00000000;
				endcase
			end
		end

		if (half_cycle_edge && state != atls_idle) begin
			next_dwell_count = dwell_count + 6'h01;
		end

		case (state)
			atls_idle: begin
				if (write_go) begin
					next_learn_go            = 1'b1;
					next_learn_complete_flag = 1'b0;
					next_dwell_count         = 6'h00;
					next_command_reg         = initial_current[7:0];
					next_override_reg        = 1'b1;
					next_state               = atls_initial;
				end
			end
			atls_initial: begin
				if (half_cycle_edge && dwell_count + 6'h01 >= dwell_target) begin
					next_learned_constant_low = measured_loss;
					next_dwell_count          = 6'h00;
					next_command_reg          = final_current[7:0];
					next_state                = atls_final;
				end
			end
			atls_final: begin
				if (half_cycle_edge && dwell_count + 6'h01 >= dwell_target) begin
					next_learned_constant_high = measured_loss;
					learn_finish               = 1'b1;
					next_learn_go              = 1'b0;
					next_learn_complete_flag   = 1'b1;
					next_command_reg           = adaptive_current_ceiling;
					next_override_reg          = 1'b0;
					next_state                 = atls_idle;
				end
			end
			default: begin
				next_state = atls_idle;
			end
		endcase
	end

	// =========================================================================
	// Loss interpolation
	logic signed [12:0] loss_slope;
	logic signed [9:0]  current_offset;
	logic signed [23:0] loss_product;
	logic signed [23:0] loss_sum;

	// The divide by the increment is a shift because every increment is a power of two.
	always_comb begin
		loss_slope     = 13'(signed'({2'b00, scaled_high})) - 13'(signed'({2'b00, scaled_low}));
		current_offset = 10'(signed'({2'b00, operating_current})) - 10'(signed'({1'b0, initial_current}));
		loss_product   = 24'(loss_slope) * 24'(current_offset);
		case (learn_increment_select)
			2'h0:    loss_sum = (loss_product >>> 7) + 24'(signed'({1'b0, scaled_low}));
			2'h1:    loss_sum = (loss_product >>> 4) + 24'(signed'({1'b0, scaled_low}));
			2'h2:    loss_sum = (loss_product >>> 5) + 24'(signed'({1'b0, scaled_low}));
			default: loss_sum = (loss_product >>> 6) + 24'(signed'({1'b0, scaled_low}));
		endcase
		if (loss_sum < 0) begin
			next_loss_reg = 11'h000;
		end else if (loss_sum > 24'sd2047) begin
			next_loss_reg = 11'h7FF;
		end else begin
			next_loss_reg = loss_sum[10:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			learn_initial_level        <= `ATLS_RST_INIT;
			learn_increment_select     <= `ATLS_RST_INC;
			learn_dwell_select         <= `ATLS_RST_DWELL;
			learn_go                   <= 1'b0;
			learn_complete_flag        <= 1'b0;
			enable_bit                 <= 1'b0;
			supply_compensation_enable <= 1'b0;
			learned_constant_low       <= `ATLS_RST_CONST;
			learned_constant_high      <= `ATLS_RST_CONST;
			adaptive_current_ceiling   <= `ATLS_RST_CEILING;
			threshold_raw              <= `ATLS_RST_THRESHOLD;
			access_done                <= 1'b0;
			state                      <= atls_idle;
			dwell_count                <= 6'h00;
			command_reg                <= 8'h00;
			override_reg               <= 1'b0;
			readdata_reg               <= 32'h00000000;
			loss_reg                   <= 11'h000;
			half_cycle_prev            <= 1'b0;
		end else begin
			learn_initial_level        <= next_learn_initial_level;
			learn_increment_select     <= next_learn_increment_select;
			learn_dwell_select         <= next_learn_dwell_select;
			learn_go                   <= next_learn_go;
			learn_complete_flag        <= next_learn_complete_flag;
			enable_bit                 <= next_enable_bit;
			supply_compensation_enable <= next_supply_compensation_enable;
			learned_constant_low       <= next_learned_constant_low;
			learned_constant_high      <= next_learned_constant_high;
			adaptive_current_ceiling   <= next_adaptive_current_ceiling;
			threshold_raw              <= next_threshold_raw;
			access_done                <= next_access_done;
			state                      <= next_state;
			dwell_count                <= next_dwell_count;
			command_reg                <= next_command_reg;
			override_reg               <= next_override_reg;
			readdata_reg               <= next_readdata_reg;
			loss_reg                   <= next_loss_reg;
			half_cycle_prev            <= half_cycle_sync;
		end
	end

	assign avs_waitrequest         = (avs_read || avs_write) && !access_done;
	assign avs_readdata            = readdata_reg;
	assign current_command         = command_reg;
	assign current_override        = override_reg;
	assign adaptive_current_enable = enable_bit;
	assign band_upper_threshold    = scaled_threshold[7:0];
	assign no_load_loss_parameter  = loss_reg;

endmodule : atls_sequencer

`default_nettype wire

/* testbench/atls_sequencer_asserts.sv */
// Port-level assertions for the learning sequencer.
`timescale 1ns/1ps
`default_nettype none

module atls_sequencer_asserts (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        half_cycle_pulse,
	input wire logic [7:0]  current_command,
	input wire logic        current_override,
	input wire logic        adaptive_current_enable,
	input wire logic [7:0]  band_upper_threshold
);
	// =========================================================================
	// Shadow of what software wrote
	logic       done_wr;
	logic [4:0] cfg_init;
	logic [1:0] cfg_inc;
	logic [1:0] cfg_dwell;
	logic [7:0] ceil_lvl;
	logic [7:0] thr;
	logic       sup;
	logic       hp_prev;
	logic [6:0] pcount;
	logic [7:0] final_lvl;
	logic [6:0] dwell2;
	assign done_wr = avs_write && !avs_waitrequest;
	assign final_lvl = {cfg_init, 3'h0} + ((cfg_inc == 2'h0) ? 8'h80 : (8'h08 << cfg_inc));
	assign dwell2 = {({1'b0, cfg_dwell} + 3'h1), 4'h0};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg_init <= 5'h00;
			cfg_inc <= 2'h0;
			cfg_dwell <= 2'h0;
			ceil_lvl <= 8'hFF;
			thr <= 8'h00;
			sup <= 1'b0;
			hp_prev <= 1'b0;
			pcount <= 7'h00;
		end else begin
			hp_prev <= half_cycle_pulse;
			// Raw edges are counted, so a pulse in flight at a boundary may shift the sum by one.
			pcount <= !current_override ? 7'h00 : pcount + 7'(half_cycle_pulse && !hp_prev);
			if (done_wr && avs_address == 8'h00) begin
				cfg_init <= avs_writedata[4:0];
				cfg_inc <= avs_writedata[9:8];
				cfg_dwell <= avs_writedata[13:12];
			end
			if (done_wr && avs_address == 8'h14) ceil_lvl <= avs_writedata[7:0];
			if (done_wr && avs_address == 8'h18) thr <= avs_writedata[7:0];
			if (done_wr && avs_address == 8'h04) sup <= avs_writedata[2];
		end
	end

	// =========================================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_go_cause;
		$rose(current_override) |-> $past(done_wr && avs_address == 8'h04 && avs_writedata[0]);
	endproperty
	a_go_cause: assert property (p_go_cause) else $error("learning began without go");
	property p_init_level;
		$rose(current_override) |-> current_command == {cfg_init, 3'h0};
	endproperty
	a_init_level: assert property (p_init_level) else $error("wrong initial level");
	property p_final_level;
		current_override && $past(current_override) && $changed(current_command)
			|-> current_command == final_lvl;
	endproperty
	a_final_level: assert property (p_final_level) else $error("wrong final level");
	property p_ceiling;
		$fell(current_override) |-> current_command == ceil_lvl;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("no ceiling after learning");
	property p_dwell;
		$fell(current_override) |-> (pcount == dwell2 || pcount == dwell2 - 7'h01);
	endproperty
	a_dwell: assert property (p_dwell) else $error("wrong dwell length");
	property p_enable;
		done_wr && avs_address == 8'h04 |=> adaptive_current_enable == $past(avs_writedata[1]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable bit not applied");
	property p_thr;
		!sup |-> band_upper_threshold == thr;
	endproperty
	a_thr: assert property (p_thr) else $error("threshold scaled while off");
	property p_wait;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus wait not one cycle");
	c_done: cover property ($fell(current_override));
	c_final: cover property (current_override && $past(current_override) && $changed(current_command));
	c_read: cover property ($rose(avs_read));
endmodule : atls_sequencer_asserts

bind atls_sequencer atls_sequencer_asserts u_asserts (.sys_clk, .reset, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_waitrequest, .half_cycle_pulse, .current_command,
	.current_override, .adaptive_current_enable, .band_upper_threshold);

`default_nettype wire

/* testbench/atls_motor_model.sv */
// Behavioural motor and regulator at the far side of the sequencer.
`timescale 1ns/1ps
`default_nettype none

module atls_motor_model (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  current_command,
	output logic             half_cycle_pulse,
	output logic      [10:0] measured_loss
);
	logic [3:0] phase;
	// Unloaded loss rises linearly with coil current, so each level leaves its own mark.
	assign measured_loss = {2'h0, current_command, 1'b0} + 11'h0A5;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			phase <= 4'h0;
		end else begin
			phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
		end
	end
	// A fixed period stands for a motor already at steady speed.
	assign half_cycle_pulse = (phase < 4'h2);
endmodule : atls_motor_model

`default_nettype wire

/* testbench/atls_sequencer_bench.sv */
// Self-checking bench for the learning sequencer with a motor model.
`timescale 1ns/1ps
`default_nettype none

module atls_sequencer_bench;
	logic        sys_clk;
	logic        reset;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        half_cycle_pulse;
	logic [10:0] measured_loss;
	logic [11:0] supply_level;
	logic [7:0]  operating_current;
	logic [7:0]  current_command;
	logic        current_override;
	logic        adaptive_current_enable;
	logic [7:0]  band_upper_threshold;
	logic [10:0] no_load_loss_parameter;
	logic [31:0] rd;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	atls_sequencer dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .half_cycle_pulse, .measured_loss,
		.supply_level, .operating_current, .current_command, .current_override,
		.adaptive_current_enable, .band_upper_threshold, .no_load_loss_parameter);
	atls_motor_model u_motor (.sys_clk, .reset, .current_command, .half_cycle_pulse,
		.measured_loss);

	// =========================================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	function automatic logic [7:0] final_of(input logic [4:0] i, input logic [1:0] c);
		return {i, 3'h0} + ((c == 2'h0) ? 8'h80 : (8'h08 << c));
	endfunction : final_of
	function automatic logic [31:0] loss_of(input logic [7:0] lvl);
		return {23'h0, lvl, 1'b0} + 32'h0A5;
	endfunction : loss_of

	// =========================================================================
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// =========================================================================
	// Main sequence
	initial begin
		logic [4:0]  init;
		logic [1:0]  inc;
		logic [7:0]  ceil_lvl;
		logic [7:0]  op;
		logic [31:0] d;
		void'($urandom(32'h8936));
		reset = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		supply_level = 12'h800;
		operating_current = 8'h00;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", (i == 5) ? 32'hFF : 32'h0, rd);
		end
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			bus(1'b1, (i == 0) ? 8'h00 : 8'(8 + 4 * i), d);
			bus(1'b0, (i == 0) ? 8'h00 : 8'(8 + 4 * i), 32'h0);
			chk("readback", d & ((i == 0) ? 32'h331F : 32'h7FF), rd);
		end
		bus(1'b1, 8'h24, 32'hFFFF_FFFF);
		bus(1'b0, 8'h24, 32'h0);
		chk("unmapped", 32'h0, rd);
		d = {24'h0, 8'($urandom)};
		bus(1'b1, 8'h18, d);
		bus(1'b1, 8'h04, 32'h4);
		supply_level <= 12'h400;
		repeat (2) @(posedge sys_clk);
		chk("scaled threshold", {d[30:0], 1'b0} & 32'hFF, {24'h0, band_upper_threshold});
		bus(1'b1, 8'h04, 32'h0);
		supply_level <= 12'h800;
		// Each pass relearns as though the motor had been swapped.
		for (int i = 0; i < 4; i++) begin
			inc = 2'(i);
			init = 5'($urandom % ((256 - final_of(5'h00, inc)) / 8));
			// The first pass keeps the recommended levels, 43 and 100 percent of the ceiling.
			if (i == 0) init = 5'h0C;
			ceil_lvl = (i == 0) ? final_of(init, inc) : 8'($urandom);
			bus(1'b1, 8'h14, {24'h0, ceil_lvl});
			bus(1'b1, 8'h04, 32'h2);
			bus(1'b1, 8'h00, {18'h0, 2'(3 - i), 2'h0, inc, 3'h0, init});
			bus(1'b1, 8'h04, 32'h3);
			bus(1'b0, 8'h08, 32'h0);
			chk("status busy", 32'h2, rd);
			do bus(1'b0, 8'h08, 32'h0); while (rd[0] !== 1'b1);
			chk("status done", 32'h1, rd);
			bus(1'b0, 8'h04, 32'h0);
			chk("go cleared", 32'h2, rd);
			bus(1'b0, 8'h0C, 32'h0);
			chk("const low", loss_of({init, 3'h0}), rd);
			bus(1'b0, 8'h10, 32'h0);
			chk("const high", loss_of(final_of(init, inc)), rd);
			chk("command", {24'h0, ceil_lvl}, {24'h0, current_command});
			chk("override", 32'h0, {31'h0, current_override});
			chk("enable", 32'h1, {31'h0, adaptive_current_enable});
			op = {init, 3'h0} + (final_of(5'h00, inc) >> 1);
			operating_current <= op;
			repeat (3) @(posedge sys_clk);
			chk("loss midpoint", loss_of(op), {21'h0, no_load_loss_parameter});
		end
		// Stored constants are restored without learning; slope 2 keeps the midpoint exact.
		d = {22'h0, 10'($urandom)};
		bus(1'b1, 8'h00, {22'h0, 2'h2, 3'h0, 5'h04});
		bus(1'b1, 8'h0C, d);
		bus(1'b1, 8'h10, d + 32'h40);
		bus(1'b1, 8'h04, 32'h2);
		operating_current <= 8'h30;
		repeat (3) @(posedge sys_clk);
		chk("restored loss", d + 32'h20, {21'h0, no_load_loss_parameter});
		give_verdict();
	end
endmodule : atls_sequencer_bench

`default_nettype wire
